// File: tb/epi_pin_model.sv
// model of the external pins that feed the interrupt block
`timescale 1ns/1ps
module epi_pin_model
    import epi_pkg::*;
(
    // clock used to time pin changes
    input  wire logic                    clock,
    // pin levels seen by the block
    output logic [EPI_NUM_EXT-1:0]       extLinePins,
    output logic [EPI_NUM_PINS-1:0]      pinChangeLine
);
    // external lines idle high as with a pull-up, change lines idle low
    initial begin
        extLinePins   = '1;
        pinChangeLine = '0;
    end

    // pins move just after a falling edge, away from the sampling edge
    task automatic setPins(input logic [1:0] e, input logic [23:0] c);
        @(negedge clock);
        extLinePins   = e;
        pinChangeLine = c;
    endtask
endmodule

// File: tb/test_external_pin_interrupts.sv
// self-checking bench of the pin interrupt block
`timescale 1ns/1ps
module test_external_pin_interrupts
    import epi_pkg::*;
;
    logic                   clock;
    logic                   rst;
    epi_reg_req_t           regReq;
    logic                   ioSpace;
    logic [7:0]             rdData;
    logic                   globalIntEn;
    epi_ack_t               intAck;
    logic [1:0]             extLinePins;
    logic [23:0]            pinChangeLine;
    logic [1:0]             extReq;
    logic [2:0]             grpReq;
    logic                   lowLevelWake;
    int                     numErrors = 0;
    int                     testsRun = 0;
    int                     cycleCount = 0;
    logic [7:0]             offs[8] = '{EPI_OFS_CHG_FLAGS, EPI_OFS_EXT_FLAGS, EPI_OFS_EXT_MASK,
        EPI_OFS_GRP_EN, EPI_OFS_EXT_SENSE, EPI_OFS_MASK0, EPI_OFS_MASK1, EPI_OFS_MASK2};
    int                     pins[5] = '{3, 9, 20, 4, 15};
    logic [7:0]             expF[5] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h00};

    epi_top dut (.clock(clock), .rst(rst), .regReq(regReq), .ioSpace(ioSpace),
        .rdData(rdData), .globalIntEn(globalIntEn), .intAck(intAck),
        .extLinePins(extLinePins), .pinChangeLine(pinChangeLine), .extReq(extReq),
        .grpReq(grpReq), .lowLevelWake(lowLevelWake));
    epi_pin_model model (.clock(clock), .extLinePins(extLinePins),
        .pinChangeLine(pinChangeLine));

    // 100 ns clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // hang guard
    always @(posedge clock) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            numErrors++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one write strobe, optionally through the i/o-space window
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
        @(negedge clock);
        regReq  = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        ioSpace = io;
        @(negedge clock);
        regReq  = '0;
        ioSpace = 1'b0;
    endtask

    // read strobe, data valid one cycle later
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(negedge clock);
        regReq = '0;
        check(rdData, exp);
    endtask

    // one-cycle vector entry pulse
    task automatic ack(input logic [4:0] a);
        @(negedge clock);
        intAck = a;
        @(negedge clock);
        intAck = '0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic close_out;
        $display("errors %0d of %0d checks", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        regReq = '0;
        ioSpace = 1'b0;
        globalIntEn = 1'b0;
        intAck = '0;
        idle(8);
        rst = 1'b0;
        foreach (offs[i]) rdChk(offs[i], EPI_RESET_VAL);
        wr(8'h50, 8'hFF);
        rdChk(8'h50, 8'h00);
        wr(EPI_OFS_MASK1, 8'hFF);
        rdChk(EPI_OFS_MASK1, EPI_MASK1_BITS);
        wr(EPI_OFS_EXT_MASK - EPI_IO_SPACE_BASE, 8'h03, 1'b1);
        rdChk(EPI_OFS_EXT_MASK, 8'h03);
        // every edge code on both lines, flags cleared by writing one
        for (int l = 0; l < 2; l++) begin
            for (int c = 1; c < 4; c++) begin
                wr(EPI_OFS_EXT_SENSE, 8'(c << (2 * l)));
                model.setPins(2'b11 ^ 2'(1 << l), 24'h0);
                idle(6);
                rdChk(EPI_OFS_EXT_FLAGS, (c != 3) ? 8'(1 << l) : 8'h00);
                check({6'h0, extReq}, 8'h00);
                wr(EPI_OFS_EXT_FLAGS, 8'h03);
                model.setPins(2'b11, 24'h0);
                idle(6);
                rdChk(EPI_OFS_EXT_FLAGS, (c != 2) ? 8'(1 << l) : 8'h00);
                wr(EPI_OFS_EXT_FLAGS, 8'h00);
                rdChk(EPI_OFS_EXT_FLAGS, (c != 2) ? 8'(1 << l) : 8'h00);
                wr(EPI_OFS_EXT_FLAGS, 8'h03);
                rdChk(EPI_OFS_EXT_FLAGS, 8'h00);
            end
        end
        // line 0 rising edge, then request gating and vector entry
        wr(EPI_OFS_EXT_SENSE, 8'h03);
        model.setPins(2'b10, 24'h0);
        model.setPins(2'b11, 24'h0);
        idle(6);
        globalIntEn = 1'b1;
        wr(EPI_OFS_EXT_MASK, 8'h02);
        idle(2);
        check({6'h0, extReq}, 8'h00);
        wr(EPI_OFS_EXT_MASK, 8'h03);
        idle(2);
        check({6'h0, extReq}, 8'h01);
        ack(5'b01000);
        idle(2);
        check({6'h0, extReq}, 8'h00);
        rdChk(EPI_OFS_EXT_FLAGS, 8'h00);
        // line 1 held low in level mode
        model.setPins(2'b01, 24'h0);
        idle(6);
        check({6'h0, extReq}, 8'h02);
        check({7'h0, lowLevelWake}, 8'h01);
        rdChk(EPI_OFS_EXT_FLAGS, 8'h00);
        model.setPins(2'b11, 24'h0);
        // pin-change groups
        wr(EPI_OFS_GRP_EN, 8'h07);
        wr(EPI_OFS_MASK0, 8'h08);
        wr(EPI_OFS_MASK1, 8'h02);
        wr(EPI_OFS_MASK2, 8'h10);
        for (int i = 0; i < 5; i++) begin
            model.setPins(2'b11, 24'(1) << pins[i]);
            idle(6);
            rdChk(EPI_OFS_CHG_FLAGS, expF[i]);
            check({5'h0, grpReq}, expF[i]);
            model.setPins(2'b11, 24'h0);
            idle(6);
            wr(EPI_OFS_CHG_FLAGS, 8'h07);
        end
        // group disabled and global bit off
        globalIntEn = 1'b0;
        wr(EPI_OFS_GRP_EN, 8'h06);
        model.setPins(2'b11, 24'h000208);
        idle(6);
        rdChk(EPI_OFS_CHG_FLAGS, 8'h02);
        check({5'h0, grpReq}, 8'h00);
        ack(5'b00010);
        rdChk(EPI_OFS_CHG_FLAGS, 8'h00);
        // mid-run reset with lines idle high: no false edge while pipeline refills
        rst = 1'b1;
        idle(3);
        rst = 1'b0;
        wr(EPI_OFS_EXT_SENSE, 8'h0F);
        idle(6);
        rdChk(EPI_OFS_EXT_FLAGS, EPI_RESET_VAL);
        rdChk(EPI_OFS_GRP_EN, EPI_RESET_VAL);
        close_out();
    end
endmodule

// File: verilog/epi_ext_detect.sv
// sense decoder of one external line: level, any change, falling or rising
`timescale 1ns/1ps
module epi_ext_detect
    import epi_pkg::*;
(
    // synchronised line and its previous sample
    input  wire logic       lineNow,
    input  wire logic       linePrev,
    // sense field
    input  wire logic [1:0] sense,
    // decoded results
    output logic            edgeHit,
    output logic            levelLow,
    output logic            isLevel
);
    // decode the two-bit sense field
    always_comb begin
        edgeHit  = 1'b0;
        levelLow = 1'b0;
        isLevel  = 1'b0;
        case (sense)
            EPI_SENSE_LOW: begin
                isLevel  = 1'b1;
                levelLow = ~lineNow;
            end
            EPI_SENSE_ANY:  edgeHit = lineNow ^ linePrev;
            EPI_SENSE_FALL: edgeHit = linePrev & ~lineNow;
            EPI_SENSE_RISE: edgeHit = lineNow & ~linePrev;
            default:        edgeHit = 1'b0;
        endcase
    end
endmodule

// File: verilog/epi_pkg.sv
// package with register map, field layout and shared types of the pin interrupt block
package epi_pkg;
    // data-space offsets of the registers
    localparam logic [7:0] EPI_OFS_CHG_FLAGS = 8'h3B;
    localparam logic [7:0] EPI_OFS_EXT_FLAGS = 8'h3C;
    localparam logic [7:0] EPI_OFS_EXT_MASK  = 8'h3D;
    localparam logic [7:0] EPI_OFS_GRP_EN    = 8'h68;
    localparam logic [7:0] EPI_OFS_EXT_SENSE = 8'h69;
    localparam logic [7:0] EPI_OFS_MASK0     = 8'h6B;
    localparam logic [7:0] EPI_OFS_MASK1     = 8'h6C;
    localparam logic [7:0] EPI_OFS_MASK2     = 8'h6D;
    // offset between data space and i/o space
    localparam logic [7:0] EPI_IO_SPACE_BASE = 8'h20;
    // reset value of every register
    localparam logic [7:0] EPI_RESET_VAL     = 8'h00;
    // implemented bits of the group-1 mask
    localparam logic [7:0] EPI_MASK1_BITS    = 8'h7F;
    // field positions
    localparam int EPI_SENSE0_LSB = 0;
    localparam int EPI_SENSE1_LSB = 2;
    localparam int EPI_NUM_EXT    = 2;
    localparam int EPI_NUM_GRP    = 3;
    localparam int EPI_NUM_PINS   = 24;
    // sense field codes
    localparam logic [1:0] EPI_SENSE_LOW  = 2'h0;
    localparam logic [1:0] EPI_SENSE_ANY  = 2'h1;
    localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
    localparam logic [1:0] EPI_SENSE_RISE = 2'h3;

    // one register access from the core
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } epi_reg_req_t;

    // interrupt entry acknowledge from the core
    typedef struct packed {
        logic [EPI_NUM_EXT-1:0] extAck;
        logic [EPI_NUM_GRP-1:0] grpAck;
    } epi_ack_t;
endpackage

// File: verilog/epi_sync.sv
// two flip-flop synchroniser with previous-value stage for change detection
`timescale 1ns/1ps
module epi_sync
    import epi_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // raw input and synchronised views
    input  wire logic [W-1:0] rawIn,
    output logic      [W-1:0] syncOut,
    output logic      [W-1:0] prevOut
);
    logic [W-1:0] meta_q;

    // first stage read only by the second stage
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q  <= '0;
            syncOut <= '0;
            prevOut <= '0;
        end else begin
            meta_q  <= rawIn;
            syncOut <= meta_q;
            prevOut <= syncOut;
        end
    end
endmodule

// File: verilog/epi_top.sv
// external line and pin-change interrupt controller
`timescale 1ns/1ps
module epi_top
    import epi_pkg::*;
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // register access from the core
    input  wire epi_reg_req_t            regReq,
    input  wire logic                    ioSpace,
    output logic [7:0]                   rdData,
    // core global interrupt bit and vector entry
    input  wire logic                    globalIntEn,
    input  wire epi_ack_t                intAck,
    // external pins
    input  wire logic [EPI_NUM_EXT-1:0]  extLinePins,
    input  wire logic [EPI_NUM_PINS-1:0] pinChangeLine,
    // requests to the core
    output logic [EPI_NUM_EXT-1:0]       extReq,
    output logic [EPI_NUM_GRP-1:0]       grpReq,
    output logic                         lowLevelWake
);
    logic [7:0] extMask_q, extSense_q, extFlags_q, grpEn_q, grpFlags_q;
    logic [7:0] mask0_q, mask1_q, mask2_q;
    logic [EPI_NUM_EXT-1:0]  extFlags_d, extNow, extPrev, extEdge, extLow, extLevel;
    logic [EPI_NUM_PINS-1:0] pinNow, pinPrev, pinMask;
    logic [EPI_NUM_GRP-1:0]  grpFlags_d, grpHit;
    logic [7:0] effAddr;
    logic       wrExtFlags, wrGrpFlags;
    logic [2:0] warm_q;
    logic       primed;
    logic [EPI_NUM_EXT-1:0]  extEdgeOk, extLowOk;

    // i/o-space accesses are shifted up into data space
    assign effAddr = ioSpace ? regReq.addr + EPI_IO_SPACE_BASE : regReq.addr;
    assign wrExtFlags = regReq.wrEn && effAddr == EPI_OFS_EXT_FLAGS;
    assign wrGrpFlags = regReq.wrEn && effAddr == EPI_OFS_CHG_FLAGS;

    // pins read regardless of their direction
    epi_sync #(.W(EPI_NUM_EXT)) uExtSync (
        .clock  (clock),
        .rst    (rst),
        .rawIn  (extLinePins),
        .syncOut(extNow),
        .prevOut(extPrev)
    );

    epi_sync #(.W(EPI_NUM_PINS)) uPinSync (
        .clock  (clock),
        .rst    (rst),
        .rawIn  (pinChangeLine),
        .syncOut(pinNow),
        .prevOut(pinPrev)
    );

    // reset zeros in the synchroniser look like a change on lines that idle
    // high, so detection waits until the sample and its predecessor are real
    always_ff @(posedge clock) begin
        if (rst) begin
            warm_q <= 3'h0;
        end else begin
            warm_q <= {warm_q[1:0], 1'b1};
        end
    end
    assign primed = warm_q[2];

    // edge and level results only count once the pipeline is primed
    assign extEdgeOk = extEdge & {EPI_NUM_EXT{primed}};
    assign extLowOk  = extLow & {EPI_NUM_EXT{primed}};

    // per-line sense decoders
    genvar gi;
    generate
        for (gi = 0; gi < EPI_NUM_EXT; gi++) begin : gExt
            epi_ext_detect uDet (
                .lineNow (extNow[gi]),
                .linePrev(extPrev[gi]),
                .sense   (extSense_q[2*gi+1:2*gi]),
                .edgeHit (extEdge[gi]),
                .levelLow(extLow[gi]),
                .isLevel (extLevel[gi])
            );
        end
    endgenerate

    // line masks: group1 bit 15 has no mask
    assign pinMask = {mask2_q, 1'b0, mask1_q[6:0], mask0_q};

    // any enabled masked line changing hits its group
    always_comb begin
        grpHit[0] = primed & grpEn_q[0] &
                    |((pinNow[7:0] ^ pinPrev[7:0]) & pinMask[7:0]);
        grpHit[1] = primed & grpEn_q[1] &
                    |((pinNow[15:8] ^ pinPrev[15:8]) & pinMask[15:8]);
        grpHit[2] = primed & grpEn_q[2] &
                    |((pinNow[23:16] ^ pinPrev[23:16]) & pinMask[23:16]);
    end

    // external flag next values
    always_comb begin
        for (int i = 0; i < EPI_NUM_EXT; i++) begin
            extFlags_d[i] = extFlags_q[i];
            if (intAck.extAck[i])
                extFlags_d[i] = 1'b0;
            if (wrExtFlags && regReq.wrData[i])
                extFlags_d[i] = 1'b0;
            if (extEdgeOk[i])
                extFlags_d[i] = 1'b1;
            if (extLevel[i])
                extFlags_d[i] = 1'b0;
        end
    end

    // group flag next values
    always_comb begin
        for (int i = 0; i < EPI_NUM_GRP; i++) begin
            grpFlags_d[i] = grpFlags_q[i];
            if (intAck.grpAck[i])
                grpFlags_d[i] = 1'b0;
            if (wrGrpFlags && regReq.wrData[i])
                grpFlags_d[i] = 1'b0;
            if (grpHit[i])
                grpFlags_d[i] = 1'b1;
        end
    end

    // flag registers
    always_ff @(posedge clock) begin
        if (rst) begin
            extFlags_q <= EPI_RESET_VAL;
            grpFlags_q <= EPI_RESET_VAL;
        end else begin
            extFlags_q <= {6'h00, extFlags_d};
            grpFlags_q <= {5'h00, grpFlags_d};
        end
    end

    // control and mask registers
    always_ff @(posedge clock) begin
        if (rst) begin
            extMask_q  <= EPI_RESET_VAL;
            extSense_q <= EPI_RESET_VAL;
            grpEn_q    <= EPI_RESET_VAL;
            mask0_q    <= EPI_RESET_VAL;
            mask1_q    <= EPI_RESET_VAL;
            mask2_q    <= EPI_RESET_VAL;
        end else if (regReq.wrEn) begin
            case (effAddr)
                EPI_OFS_EXT_MASK:  extMask_q  <= {6'h00, regReq.wrData[1:0]};
                EPI_OFS_EXT_SENSE: extSense_q <= {4'h0, regReq.wrData[3:0]};
                EPI_OFS_GRP_EN:    grpEn_q    <= {5'h00, regReq.wrData[2:0]};
                EPI_OFS_MASK0:     mask0_q    <= regReq.wrData;
                EPI_OFS_MASK1:     mask1_q    <= regReq.wrData & EPI_MASK1_BITS;
                EPI_OFS_MASK2:     mask2_q    <= regReq.wrData;
                default:           extMask_q  <= extMask_q;
            endcase
        end
    end

    // register read port, one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            rdData <= EPI_RESET_VAL;
        end else if (regReq.rdEn) begin
            case (effAddr)
                EPI_OFS_CHG_FLAGS: rdData <= grpFlags_q;
                EPI_OFS_EXT_FLAGS: rdData <= extFlags_q;
                EPI_OFS_EXT_MASK:  rdData <= extMask_q;
                EPI_OFS_GRP_EN:    rdData <= grpEn_q;
                EPI_OFS_EXT_SENSE: rdData <= extSense_q;
                EPI_OFS_MASK0:     rdData <= mask0_q;
                EPI_OFS_MASK1:     rdData <= mask1_q;
                EPI_OFS_MASK2:     rdData <= mask2_q;
                default:           rdData <= 8'h00;
            endcase
        end
    end

    // vector requests to the core; level lines request while low
    always_ff @(posedge clock) begin
        if (rst) begin
            extReq       <= '0;
            grpReq       <= '0;
            lowLevelWake <= 1'b0;
        end else begin
            for (int i = 0; i < EPI_NUM_EXT; i++) begin
                extReq[i] <= globalIntEn & extMask_q[i] &
                             (extFlags_q[i] | extLowOk[i]);
            end
            grpReq       <= {3{globalIntEn}} & grpEn_q[2:0] & grpFlags_q[2:0];
            lowLevelWake <= |(extMask_q[1:0] & extLowOk);
        end
    end

    // checks: flag clearing by a write of one and by vector entry, flag kept on a write of zero
    a_flag_w1c: assert property (@(posedge clock) disable iff (rst)
        wrExtFlags && regReq.wrData[0] && !extEdgeOk[0] |=> !extFlags_q[0])
        else $error("line 0 flag survived a write of one");
    a_ext1_w1c: assert property (@(posedge clock) disable iff (rst)
        wrExtFlags && regReq.wrData[1] && !extEdgeOk[1] |=> !extFlags_q[1])
        else $error("line 1 flag survived a write of one");
    a_zero_keeps: assert property (@(posedge clock) disable iff (rst)
        wrExtFlags && !regReq.wrData[0] && !intAck.extAck[0] && !extLevel[0] &&
        extFlags_q[0] |=> extFlags_q[0])
        else $error("line 0 flag lost on a write of zero");
    a_grp_w1c: assert property (@(posedge clock) disable iff (rst)
        wrGrpFlags && regReq.wrData[2] && !grpHit[2] |=> !grpFlags_q[2])
        else $error("group 2 flag survived a write of one");
    a_ext_entry: assert property (@(posedge clock) disable iff (rst)
        intAck.extAck[0] && !extEdgeOk[0] |=> !extFlags_q[0])
        else $error("line 0 flag kept after entry");
    a_ext1_entry: assert property (@(posedge clock) disable iff (rst)
        intAck.extAck[1] && !extEdgeOk[1] |=> !extFlags_q[1])
        else $error("line 1 flag kept after entry");
    a_ack_clear: assert property (@(posedge clock) disable iff (rst)
        intAck.grpAck[1] && !grpHit[1] |=> !grpFlags_q[1])
        else $error("group 1 flag kept after entry");

    // checks: flags set by edges and changes, cleared in level mode
    a_set_wins: assert property (@(posedge clock) disable iff (rst)
        extEdgeOk[0] && !extLevel[0] |=> extFlags_q[0])
        else $error("line 0 edge lost");
    a_ext1_set: assert property (@(posedge clock) disable iff (rst)
        extEdgeOk[1] |=> extFlags_q[1])
        else $error("line 1 edge lost");
    a_level_clear: assert property (@(posedge clock) disable iff (rst)
        extLevel[1] |=> !extFlags_q[1])
        else $error("line 1 flag set in level mode");
    a_pin_flag: assert property (@(posedge clock) disable iff (rst)
        primed && grpEn_q[0] && mask0_q[3] && $changed(pinNow[3]) |=> grpFlags_q[0])
        else $error("group 0 change missed");
    a_grp2_line: assert property (@(posedge clock) disable iff (rst)
        primed && grpEn_q[2] && mask2_q[4] && $changed(pinNow[20]) |=> grpFlags_q[2])
        else $error("group 2 change missed");
    a_grp_set: assert property (@(posedge clock) disable iff (rst)
        grpHit[1] |=> grpFlags_q[1])
        else $error("group 1 change lost");
    a_unused_line: assert property (@(posedge clock) disable iff (rst)
        $changed(pinNow[15]) && $stable(pinNow[14:8]) |-> !grpHit[1])
        else $error("group 1 hit by the unused line");

    // checks: requests to the core
    a_ext_gate: assert property (@(posedge clock) disable iff (rst)
        extReq[0] |-> $past(globalIntEn) && $past(extMask_q[0]))
        else $error("line 0 request without enables");
    a_ext1_gate: assert property (@(posedge clock) disable iff (rst)
        extReq[1] |-> $past(globalIntEn) && $past(extMask_q[1]))
        else $error("line 1 request without enables");
    a_ext_req: assert property (@(posedge clock) disable iff (rst)
        globalIntEn && extMask_q[1] && extFlags_q[1] |=> extReq[1])
        else $error("line 1 request missing");
    a_level_req: assert property (@(posedge clock) disable iff (rst)
        globalIntEn && extMask_q[0] && extLevel[0] && !extNow[0] && primed |=> extReq[0])
        else $error("line 0 low level not requested");
    a_wake_src: assert property (@(posedge clock) disable iff (rst)
        lowLevelWake |-> $past(extLevel[0]) || $past(extLevel[1]))
        else $error("wake without a level-sensed line");
    a_grp_req: assert property (@(posedge clock) disable iff (rst)
        globalIntEn && grpEn_q[2] && grpFlags_q[2] |=> grpReq[2])
        else $error("group 2 request missing");
    a_grp_src: assert property (@(posedge clock) disable iff (rst)
        grpReq[1] |-> $past(grpFlags_q[1]) && $past(grpEn_q[1]))
        else $error("group 1 request without flag and enable");
    a_grp_gate: assert property (@(posedge clock) disable iff (rst)
        !globalIntEn |=> grpReq == 3'h0)
        else $error("group request without the global bit");

    // checks: register contents
    a_mask1_top: assert property (@(posedge clock) disable iff (rst)
        !mask1_q[7])
        else $error("group 1 mask bit 7 set");
    a_rst_zero: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> extFlags_q == EPI_RESET_VAL && grpFlags_q == EPI_RESET_VAL &&
        extMask_q == EPI_RESET_VAL && grpEn_q == EPI_RESET_VAL)
        else $error("register not zero after reset");

    // main scenarios
    c_ext_edge: cover property (@(posedge clock) disable iff (rst) extReq[0]);
    c_grp_req:  cover property (@(posedge clock) disable iff (rst) grpReq[1]);
    c_set_clr:  cover property (@(posedge clock) disable iff (rst) grpHit[0] && wrGrpFlags);
    c_level:    cover property (@(posedge clock) disable iff (rst) lowLevelWake);
    c_entry:    cover property (@(posedge clock) disable iff (rst) intAck.extAck[0]);
endmodule
